// file: scl_strap_config_latch.sv
// Purpose: latch strap codes during reset and present them as config defaults
// Assumes: at least one clock edge occurs while reset is held
// Notes: AXI4-Lite slave exposes captured word and the management address
//
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module scl_strap_config_latch
    import scl_pkg::*;
#(
    parameter int PINS = STRAP_PINS
)
(
    input wire logic clock,
    input wire logic reset,
    input wire logic [PINS-1:0] config_strap_pins,
    input wire logic [3*PINS-1:0] strap_level,
    input wire logic [4:0] mgmt_addr_in,
    output logic mgmt_addr_match,
    output logic [4:0] phy_address,
    output logic [3:0] operating_mode,
    output logic sfp_mode_disable,
    output logic signal_detect_pin_dir,
    output logic serdes_impedance,
    output logic [1:0] led_control,
    output logic heartbeat_test_en,
    output logic echo_10bt,
    output logic [1:0] aneg_adv_ctrl,
    output logic led_pulsing,
    output logic register_view,
    output logic [1:0] tx_timing_comp,
    output logic [1:0] rx_timing_comp,
    output logic backplane_low_power,
    output logic signal_detect_pin_pol,
    output logic enhanced_pd_en,
    output logic host_clock_output_freq,
    output logic link_act_behaviour,
    output logic downshift_en,
    output logic [1:0] flow_control,
    output logic mode_is_copper,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic [CFG_W-1:0] cfg;
    logic reset_seen;
    logic [4:0] addr_ovr;
    logic ovr_en;

    // One capture cell per strap pin
    genvar gi;
    generate
        for (gi = 0; gi < PINS; gi++) begin : g_pin
            scl_pin_capture u_cap (
                .clock(clock),
                .reset(reset),
                .pulled_up(config_strap_pins[gi]),
                .level(strap_level[3*gi +: 3]),
                .code(cfg[CODE_W*gi +: CODE_W])
            );
        end
    endgenerate

    // Field decode from captured word
    wire [4:0] strap_addr = {cfg[F_ADDR_HI], cfg[F_ADDR_LO +: 4]}; // RULE5
    wire [4:0] active_addr = ovr_en ? addr_ovr : strap_addr;
    wire [3:0] strap_mode = cfg[F_MODE +: 4]; // RULE5 RULE8

    function automatic logic copper_mode(input logic [3:0] m);
        case (scl_mode_t'(m))
            SCL_GMII_FIBER, SCL_RGMII_FIBER, SCL_TBI_FIBER, SCL_SERIAL_FIBER: copper_mode = 1'b0;
            default: copper_mode = 1'b1;
        endcase
    endfunction

    // Config outputs registered; zero while reset samples the pins, then loaded each clock from the captured word, phy_address from addr_ovr when ovr_en
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            reset_seen <= 1'b1;
            {phy_address, operating_mode, mode_is_copper} <= 10'h000;
            {sfp_mode_disable, signal_detect_pin_dir, serdes_impedance} <= 3'h0;
            {led_control, heartbeat_test_en, echo_10bt, aneg_adv_ctrl} <= 6'h00;
            {led_pulsing, register_view, tx_timing_comp, rx_timing_comp} <= 6'h00;
            {backplane_low_power, signal_detect_pin_pol, enhanced_pd_en} <= 3'h0;
            {host_clock_output_freq, link_act_behaviour, downshift_en} <= 3'h0;
            flow_control <= 2'h0;
            mgmt_addr_match <= 1'b0;
        end else begin
            reset_seen <= 1'b0;
            phy_address <= active_addr; // RULE2 RULE7
            operating_mode <= strap_mode; // RULE8
            mode_is_copper <= copper_mode(strap_mode); // RULE8
            sfp_mode_disable <= cfg[F_SFP_DIS]; // RULE5
            signal_detect_pin_dir <= cfg[F_SIGNAL_DETECT_PIN_DIR]; // RULE5
            serdes_impedance <= cfg[F_SERDES_IMP]; // RULE5
            led_control <= {cfg[F_LED1], cfg[F_LED0]}; // RULE6
            heartbeat_test_en <= cfg[F_HEARTBEAT]; // RULE6
            echo_10bt <= cfg[F_ECHO]; // RULE6
            aneg_adv_ctrl <= {cfg[F_ANEG1], cfg[F_ANEG0]}; // RULE6
            led_pulsing <= cfg[F_PULSE]; // RULE6
            register_view <= cfg[F_VIEW]; // RULE6
            tx_timing_comp <= cfg[F_TX_TIMING +: 2]; // RULE6
            rx_timing_comp <= cfg[F_RX_TIMING +: 2]; // RULE6
            backplane_low_power <= cfg[F_BP_LOWPWR]; // RULE6
            signal_detect_pin_pol <= cfg[F_SIGNAL_DETECT_PIN_POL]; // RULE6
            enhanced_pd_en <= cfg[F_EPD_EN]; // RULE6
            host_clock_output_freq <= cfg[F_CLK_FREQ]; // RULE6
            link_act_behaviour <= cfg[F_LINK_ACT]; // RULE6
            downshift_en <= cfg[F_DOWNSHIFT]; // RULE6
            flow_control <= cfg[F_FLOW +: 2]; // RULE6
            mgmt_addr_match <= (mgmt_addr_in == active_addr); // RULE7
        end
    end

    // AXI4-Lite write path: takes address and data in either order
    logic aw_held;
    logic w_held;
    logic [3:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire have_aw = aw_held || aw_take;
    wire have_w = w_held || w_take;
    wire [3:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
    wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
    wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;
    wire wr_fire = have_aw && have_w && !s_axi_bvalid;
    wire wr_hit = (wr_addr == ADDR_MGMT_OVR);
    wire wr_ro = (wr_addr == ADDR_STRAP_WORD) || (wr_addr == ADDR_EXT_CTRL);

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 4'h0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            addr_ovr <= 5'h00;
            ovr_en <= 1'b0;
        end else begin
            s_axi_awready <= !have_aw && !s_axi_awready;
            s_axi_wready <= !have_w && !s_axi_wready;
            if (aw_take) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (w_take) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_awready <= 1'b0;
                s_axi_wready <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_hit || wr_ro) ? RESP_OKAY : RESP_SLVERR;
                // Software override of the strapped management address
                if (wr_hit && wr_strb[0]) begin
                    addr_ovr <= wr_data[4:0];
                    ovr_en <= wr_data[7];
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // AXI4-Lite read path, one cycle after the address
    wire [31:0] rd_mux =
        (s_axi_araddr == ADDR_STRAP_WORD) ? cfg :
        (s_axi_araddr == ADDR_EXT_CTRL) ? (32'(active_addr) << EXT_ADDR_LSB) :
        (s_axi_araddr == ADDR_MGMT_OVR) ? {24'h00_0000, ovr_en, 2'h0, addr_ovr} :
        32'h0000_0000;
    wire rd_ok = (s_axi_araddr == ADDR_STRAP_WORD) || (s_axi_araddr == ADDR_EXT_CTRL) ||
        (s_axi_araddr == ADDR_MGMT_OVR);

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux; // RULE7
                s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Captured word must not move outside reset
    chk_word_held: assert property (@(posedge clock) disable iff (reset)
        !reset_seen |-> cfg == $past(cfg)) else $error("strap word changed"); // RULE9
    chk_addr_follow: assert property (@(posedge clock) disable iff (reset)
        (!ovr_en && !reset_seen) |=> phy_address == $past(strap_addr))
        else $error("address not from straps"); // RULE5
    chk_mode_follow: assert property (@(posedge clock) disable iff (reset)
        !reset_seen |=> operating_mode == cfg[F_MODE +: 4])
        else $error("mode not from straps"); // RULE8
    chk_flow_follow: assert property (@(posedge clock) disable iff (reset)
        !reset_seen |=> flow_control == cfg[F_FLOW +: 2] && led_control[1] == cfg[F_LED1])
        else $error("field not from straps"); // RULE6
    chk_rail_bit: assert property (@(posedge clock) disable iff (reset)
        $fell(reset_seen) |-> cfg[RAIL_BIT] == $past(config_strap_pins[0], 2))
        else $error("rail bit wrong"); // RULE3
    chk_level_bits: assert property (@(posedge clock) disable iff (reset)
        $fell(reset_seen) |-> cfg[2:0] == $past(strap_level[2:0], 2))
        else $error("level bits wrong"); // RULE4
    chk_match_addr: assert property (@(posedge clock) disable iff (reset)
        !reset_seen && mgmt_addr_in == active_addr |=> mgmt_addr_match)
        else $error("address match missed"); // RULE7
    chk_bresp_follows: assert property (@(posedge clock) disable iff (reset)
        wr_fire |=> s_axi_bvalid ##0 $stable(cfg)) else $error("write response missing"); // RULE2
endmodule

// file: scl_pkg.sv
// Purpose: constants for the strap configuration latch
// Assumes: strap codes arrive already quantised to four bits per pin
// Notes: field positions index the 32-bit captured word, pin n at bits 4n+3:4n
// Summary of operation
// RULE1: During reset each of the eight strap pins is sampled as a four-bit code, 32 bits in all.
// RULE2: Every captured bit becomes the power-up default of one configuration field output.
// RULE3: Code bit 3 is 1 for a pull to the analog supply rail and 0 for a pull to ground.
// RULE4: Code bits 2:0 rise with resistor value, 000 for a direct tie up to 111 for 22.6k.
// RULE5: Pin 0 gives address 3:0, pin 1 gives address 4, module-mode disable, detect direction, impedance; pin 2 gives mode.
// RULE6: Pins 3 to 7 give LED, heartbeat, echo, advertisement, pulsing, view, timing, power and flow fields.
// RULE7: The five-bit address selects the management address and is readable in a control register.
// RULE8: The four-bit operating mode selects the MAC to media interface combination.
// RULE9: Captured codes hold from reset release until the next reset, ignoring later pin changes.
package scl_pkg;
    localparam int STRAP_PINS = 8;
    localparam int CODE_W = 4;
    localparam int CFG_W = 32;
    localparam int RAIL_BIT = 3;
    localparam logic [2:0] LEVEL_TIE = 3'h0;
    localparam logic [2:0] LEVEL_MAX = 3'h7;
    // Field positions in the captured word
    localparam int F_ADDR_LO = 0;
    localparam int F_ADDR_HI = 6;
    localparam int F_SERDES_IMP = 4;
    localparam int F_SIGNAL_DETECT_PIN_DIR = 5;
    localparam int F_SFP_DIS = 7;
    localparam int F_MODE = 8;
    localparam int F_ANEG1 = 12;
    localparam int F_ECHO = 13;
    localparam int F_HEARTBEAT = 14;
    localparam int F_LED1 = 15;
    localparam int F_VIEW = 16;
    localparam int F_ANEG0 = 17;
    localparam int F_PULSE = 18;
    localparam int F_LED0 = 19;
    localparam int F_RX_TIMING = 20;
    localparam int F_TX_TIMING = 22;
    localparam int F_CLK_FREQ = 24;
    localparam int F_EPD_EN = 25;
    localparam int F_SIGNAL_DETECT_PIN_POL = 26;
    localparam int F_BP_LOWPWR = 27;
    localparam int F_FLOW = 28;
    localparam int F_DOWNSHIFT = 30;
    localparam int F_LINK_ACT = 31;
    // Register map, byte addresses
    localparam logic [3:0] ADDR_STRAP_WORD = 4'h0;
    localparam logic [3:0] ADDR_EXT_CTRL = 4'h4;
    localparam logic [3:0] ADDR_MGMT_OVR = 4'h8;
    localparam int EXT_ADDR_LSB = 11;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Operating mode codes
    typedef enum logic [3:0] {
        SCL_SERDES_CAT5_AS = 4'h0, SCL_RGMII_AUTO = 4'h1, SCL_GMII_FIBER = 4'h2,
        SCL_GMII_AUTO = 4'h3, SCL_SERDES_NO37 = 4'h4, SCL_SGMII_CLK = 4'h5,
        SCL_RGMII_CAT5 = 4'h6, SCL_RGMII_FIBER = 4'h7, SCL_GMII_CAT5 = 4'h8,
        SCL_TBI_CAT5 = 4'h9, SCL_SERDES_CONV = 4'ha, SCL_TBI_FIBER = 4'hb,
        SCL_RTBI_CAT5 = 4'hc, SCL_SERIAL_FIBER = 4'hd, SCL_SERDES_C37 = 4'he,
        SCL_SGMII_NOCLK = 4'hf
    } scl_mode_t;
endpackage

// file: scl_pin_capture.sv
// Purpose: one strap pin, forms and holds its four-bit code
// Assumes: level arrives as a 3-bit resistor bucket plus a pull direction
// Notes: capture is open only while reset is high
`timescale 1ns/1ps
module scl_pin_capture
    import scl_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic pulled_up,
    input wire logic [2:0] level,
    output logic [CODE_W-1:0] code
);
    // Direction in the top bit, resistor bucket below
    wire [CODE_W-1:0] next_code = {pulled_up, level}; // RULE3 RULE4

    // Asynchronous reset cannot load a pin value, so sample on clock while held
    always_ff @(posedge clock) begin
        if (reset) begin
            code <= next_code; // RULE1 RULE9
        end
    end
endmodule

// file: scl_strap_board.sv
// Purpose: board strap resistors seen as pin direction and resistor bucket
// Assumes: quantiser is ideal, so the bucket equals the code's low bits
// Notes: the code word is laid out pin n at bits 4n+3:4n
`timescale 1ns/1ps
module scl_strap_board
    import scl_pkg::*;
(
    input wire logic [CFG_W-1:0] codes,
    output logic [STRAP_PINS-1:0] pull_up,
    output logic [3*STRAP_PINS-1:0] level
);
    // Split each pin code into rail choice and resistor size
    always_comb begin
        for (int n = 0; n < STRAP_PINS; n++) begin
            pull_up[n] = codes[4*n+RAIL_BIT];
            level[3*n +: 3] = codes[4*n +: 3];
        end
    end
endmodule

// file: test_strap_config_latch.sv
// Purpose: self-checking bench for the strap configuration latch
// Assumes: board model turns a 32-bit code word into pin levels
// Notes: every capture needs a fresh reset, codes latch only then
`timescale 1ns/1ps
module test_strap_config_latch
    import scl_pkg::*;
;
    logic clock = 1'b0, reset = 1'b1;
    logic [31:0] codes = 32'h0, got, s_axi_wdata = 32'h0, s_axi_rdata;
    logic [7:0] pins;
    logic [23:0] lvl;
    logic [4:0] mgmt_addr_in = 5'h0, phy_address;
    logic [3:0] operating_mode, s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
    logic [1:0] led_control, aneg_adv_ctrl, tx_timing_comp, rx_timing_comp, flow_control;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic mgmt_addr_match, sfp_mode_disable, signal_detect_pin_dir, serdes_impedance;
    logic heartbeat_test_en, echo_10bt, led_pulsing, register_view, backplane_low_power;
    logic signal_detect_pin_pol, enhanced_pd_en, host_clock_output_freq, link_act_behaviour;
    logic downshift_en, mode_is_copper, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    int fail_count = 0, checks = 0;

    scl_strap_board scl_strap_board_inst (.codes, .pull_up(pins), .level(lvl));
    scl_strap_config_latch scl_strap_config_latch_inst (
        .clock, .reset, .config_strap_pins(pins), .strap_level(lvl), .mgmt_addr_in,
        .mgmt_addr_match, .phy_address, .operating_mode, .sfp_mode_disable,
        .signal_detect_pin_dir, .serdes_impedance, .led_control, .heartbeat_test_en,
        .echo_10bt, .aneg_adv_ctrl, .led_pulsing, .register_view, .tx_timing_comp,
        .rx_timing_comp, .backplane_low_power, .signal_detect_pin_pol, .enhanced_pd_en,
        .host_clock_output_freq, .link_act_behaviour, .downshift_en, .flow_control,
        .mode_is_copper, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
    );

    // Fields put back where the pin table places them, pin 7 on top
    assign got = {link_act_behaviour, downshift_en, flow_control, backplane_low_power,
        signal_detect_pin_pol, enhanced_pd_en, host_clock_output_freq, tx_timing_comp,
        rx_timing_comp, led_control[0], led_pulsing, aneg_adv_ctrl[0], register_view,
        led_control[1], heartbeat_test_en, echo_10bt, aneg_adv_ctrl[1], operating_mode,
        sfp_mode_disable, phy_address[4], signal_detect_pin_dir, serdes_impedance,
        phy_address[3:0]};

    always #50 clock = ~clock;

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Write: both channels offered together, each dropped at its own handshake edge;
    // the response is watched on every edge since it may close while a channel waits
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
        output logic [1:0] r);
        logic aw_done;
        logic w_done;
        logic b_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        b_done = 1'b0;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b_done) begin
            @(posedge clock);
            if (!aw_done && s_axi_awready === 1'b1) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready === 1'b1) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
            if (s_axi_bvalid === 1'b1) begin
                b_done = 1'b1;
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
            end
        end
    endtask

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clock); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clock); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // Full reset with a new board word, sampled once outputs settle
    task automatic load(input logic [31:0] w);
        if (reset !== 1'b1) @(posedge clock);
        reset <= 1'b1;
        codes <= w;
        repeat (6) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        @(negedge clock);
    endtask

    task automatic t_capture(input logic [31:0] w);
        logic [31:0] d;
        logic [1:0] r;
        load(w);
        check("fields", got, w);
        check("rail bit", 32'(sfp_mode_disable), 32'(w[7]));
        check("level bits", 32'(phy_address[2:0]), 32'(w[2:0]));
        axi_rd(ADDR_STRAP_WORD, d, r);
        check("word", d, w);
        check("word resp", 32'(r), 32'(RESP_OKAY));
        axi_rd(ADDR_EXT_CTRL, d, r);
        check("ext addr", 32'(d[15:11]), 32'({w[6], w[3:0]}));
        codes <= ~w;
        repeat (4) @(negedge clock);
        check("held", got, w);
    endtask

    task automatic t_modes();
        logic [3:0] m;
        for (int i = 0; i < 16; i++) begin
            m = 4'(i);
            load({20'h0, m, 8'h0});
            check("mode", 32'(operating_mode), 32'(m));
            check("copper", 32'(mode_is_copper), 32'(!(m inside {4'h2, 4'h7, 4'hb, 4'hd})));
        end
    endtask

    // Strap address 5'h11, then a software override to 5'h05
    task automatic t_mgmt();
        logic [31:0] d;
        logic [1:0] r;
        load(32'h0000_0051);
        @(posedge clock);
        mgmt_addr_in <= 5'h11;
        repeat (3) @(negedge clock);
        check("match", 32'(mgmt_addr_match), 32'h1);
        axi_wr(ADDR_MGMT_OVR, 32'h0000_0085, 4'hf, r);
        check("ovr resp", 32'(r), 32'(RESP_OKAY));
        repeat (3) @(negedge clock);
        check("no match", 32'(mgmt_addr_match), 32'h0);
        @(posedge clock);
        mgmt_addr_in <= 5'h05;
        repeat (3) @(negedge clock);
        check("ovr match", 32'(mgmt_addr_match), 32'h1);
        axi_rd(ADDR_EXT_CTRL, d, r);
        check("ext ovr", 32'(d[15:11]), 32'h05);
        // Low byte strobe off, so the override must stay as it was
        axi_wr(ADDR_MGMT_OVR, 32'h0000_0000, 4'h0, r);
        axi_rd(ADDR_MGMT_OVR, d, r);
        check("strb off", d, 32'h0000_0085);
        axi_rd(4'hc, d, r);
        check("bad rd", {d[29:0], r}, {30'h0, RESP_SLVERR});
        axi_wr(4'hc, 32'h1, 4'hf, r);
        check("bad wr", 32'(r), 32'(RESP_SLVERR));
    endtask

    initial begin
        t_capture(32'h9a5c3e71);
        t_capture(32'h6f0812ed);
        t_modes();
        t_mgmt();
        tally_and_finish();
    end

    // Watchdog; the run needs well under a thousand cycles
    initial begin
        repeat (3000) @(posedge clock);
        fail_count++;
        tally_and_finish();
    end
endmodule
